// ### include/vca_cfg.svh
`ifndef VCA_CFG_SVH
`define VCA_CFG_SVH

// Register offsets on the host register port
`define VCA_ADDR_CONTRAST 8'h3a
`define VCA_ADDR_SATURATION 8'h3b
`define VCA_ADDR_BRIGHTNESS 8'h3c
`define VCA_ADDR_HUE 8'h3d
`define VCA_ADDR_ADJ_CTRL 8'h3e
`define VCA_ADDR_CLAMP_CTRL 8'h6c
`define VCA_ADDR_CLAMP_A_LO 8'h6d
`define VCA_ADDR_CLAMP_B_LO 8'h6e
`define VCA_ADDR_CLAMP_BC 8'h6f
`define VCA_ADDR_CLAMP_C_LO 8'h70

// Field positions
`define VCA_BIT_ADJ_EN 7
`define VCA_BIT_CLAMP_A_SEL 7
`define VCA_BIT_CLAMP_BC_SEL 6
`define VCA_BIT_CLAMP_FREEZE 5

// Reset values
`define VCA_RST_CONTRAST 8'h80
`define VCA_RST_SATURATION 8'h80
`define VCA_RST_BRIGHTNESS 8'h00
`define VCA_RST_HUE 8'h00
`define VCA_RST_ADJ_CTRL 8'h00
`define VCA_RST_CLAMP_CTRL 8'h00
`define VCA_RST_CLAMP_VALUE 12'h000

// Pass-through converter settings and datapath constants
`define VCA_COEFF_SEL_MANUAL 4'h0
`define VCA_SCALE_DEFAULT 2'h1
`define VCA_ACTIVE_MODE 4'h5
`define VCA_CHROMA_MID 32'sh0000_0800
`define VCA_UNITY_SHIFT 7
`define VCA_TRIG_SHIFT 10
`define VCA_FIFO_DEPTH 8

`endif

// ### include/vca_pkg.sv
`default_nettype none

package vca_pkg;
  // One channel sample
  typedef logic [11:0] vca_px_t;
  // Signed working width of the colour arithmetic
  typedef logic signed [31:0] vca_wide_t;
  // Source of a channel's clamp amount
  typedef enum logic {VCA_CLAMP_MANUAL = 1'b0, VCA_CLAMP_LOOP = 1'b1} vca_clamp_src_t;
endpackage : vca_pkg

`default_nettype wire

// ### logic/vca_top.sv
// Behaviour
// - Converter with manual enable, selector zero and default scale leaves pixels unchanged.
// - Preprocessor converter only acts for RGB in, RGB out with adjust enabled.
// - Adjust enable bit, default off, gates contrast, saturation, brightness and hue.
// - Contrast is unsigned 1.7 factor, default 0x80 meaning unity.
// - Saturation is unsigned 1.7 factor applied to both chroma channels.
// - Brightness is signed code times four added to luma, -512 to +508.
// - Hue rotates chroma: Cb cos plus Cr sin, Cr cos minus Cb sin.
// - Hue 0x00 is 0, 0x40 90, 0x80 180, 0xC0 270 degrees.
// - Pixel rates above 170 MHz bypass this processor entirely.
// - Processor acts only in the selected operating mode and video standard.
// - Horizontal sync, vertical sync, field and data enable travel with pixels.
// - Three per-channel clamp loops measure the back porch and correct the stream.
// - Clamp loops drive black input toward code zero.
// - Independent offset adder after the gain stage lets black map non-zero.
// - Freeze bit stops all three loops; current offsets stay applied.
// - Channel A select zero uses manual value, one uses loop value.
// - Channel A manual clamp is twelve-bit unsigned, split high nibble and low byte.
// - Channel A high written first, low second; value applies as one update.
// - Channels B and C share one manual or loop selection.
// - Shared select zero uses manual B and C values, one uses loop values.
// - Channel B manual value, low byte then high nibble, applied as one.
// - Channel C manual value, high nibble then low byte, applied as one.
`include "vca_cfg.svh"
`default_nettype none

// Synchronous FIFO with back-pressure on both sides
module vca_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Pointer comparison with one wrap bit
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;
  assign o_out_data = mem[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : vca_fifo

// One fine clamp loop: steps its level by one code per line toward the back-porch level
module vca_clamp_loop
  import vca_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_bp_sample,
  input wire logic i_line_start,
  input wire logic i_freeze,
  input wire vca_px_t i_sample,
  output vca_px_t o_level
);
  logic err_up;
  logic err_down;

  // Latest back-porch error sign against the current level
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      err_up <= 1'b0;
      err_down <= 1'b0;
    end
    else if (i_line_start)
    begin
      err_up <= 1'b0;
      err_down <= 1'b0;
    end
    else if (i_bp_sample)
    begin
      err_up <= (i_sample > o_level);
      err_down <= (i_sample < o_level);
    end
  end

  // Level update once per active line, held while frozen
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_level <= `VCA_RST_CLAMP_VALUE;
    end
    else if (i_line_start && !i_freeze)
    begin
      if (err_up && o_level != 12'hfff)
      begin
        o_level <= o_level + 12'h001;
      end
      else if (err_down && o_level != 12'h000)
      begin
        o_level <= o_level - 12'h001;
      end
    end
  end
endmodule : vca_clamp_loop

// Colour adjust and fine clamp processor
module vca_top
  import vca_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_manual_converter_enable,
  input wire logic [3:0] i_converter_coefficient_selector,
  input wire logic [1:0] i_converter_output_scaler,
  input wire logic i_input_is_rgb,
  input wire logic i_output_is_rgb,
  input wire logic [3:0] i_primary_operating_mode,
  input wire logic [5:0] i_video_standard_select,
  input wire logic i_pixel_rate_over_limit,
  input wire vca_px_t i_offset_a,
  input wire vca_px_t i_offset_b,
  input wire vca_px_t i_offset_c,
  input wire logic i_px_valid,
  output logic o_px_ready,
  input wire vca_px_t i_px_a,
  input wire vca_px_t i_px_b,
  input wire vca_px_t i_px_c,
  input wire logic i_hsync,
  input wire logic i_vsync,
  input wire logic i_field,
  input wire logic i_de,
  output logic o_px_valid,
  input wire logic i_out_ready,
  output vca_px_t o_px_a,
  output vca_px_t o_px_b,
  output vca_px_t o_px_c,
  output logic o_hsync,
  output logic o_vsync,
  output logic o_field,
  output logic o_de,
  output logic o_preproc_convert,
  output logic o_bypass_to_formatter
);
  // Quarter-wave sine, 1024 is one, 65 points over 0..90 degrees
  localparam logic [10:0] SIN_Q [0:64] = '{
    11'd0, 11'd25, 11'd50, 11'd75, 11'd100, 11'd125, 11'd150, 11'd175,
    11'd200, 11'd224, 11'd249, 11'd273, 11'd297, 11'd321, 11'd345, 11'd369,
    11'd392, 11'd415, 11'd438, 11'd460, 11'd483, 11'd505, 11'd526, 11'd548,
    11'd569, 11'd590, 11'd610, 11'd630, 11'd650, 11'd669, 11'd688, 11'd706,
    11'd724, 11'd742, 11'd759, 11'd775, 11'd792, 11'd807, 11'd822, 11'd837,
    11'd851, 11'd865, 11'd878, 11'd891, 11'd903, 11'd915, 11'd926, 11'd936,
    11'd946, 11'd955, 11'd964, 11'd972, 11'd980, 11'd987, 11'd993, 11'd999,
    11'd1004, 11'd1009, 11'd1013, 11'd1016, 11'd1019, 11'd1021, 11'd1023, 11'd1024,
    11'd1024};

  // Sine of code*360/256 degrees, signed with 1024 as one
  function automatic vca_wide_t hue_sin(input logic [7:0] code);
    logic [6:0] idx;
    vca_wide_t mag;
    idx = code[6] ? (7'd64 - {1'b0, code[5:0]}) : {1'b0, code[5:0]};
    mag = vca_wide_t'({21'd0, SIN_Q[idx]});
    return code[7] ? -mag : mag;
  endfunction : hue_sin

  // Clip a wide signed value into the twelve-bit code range
  function automatic vca_px_t clip12(input vca_wide_t v);
    if (v < 0)
      return 12'h000;
    else if (v > 32'sd4095)
      return 12'hfff;
    else
      return v[11:0];
  endfunction : clip12

  logic [7:0] contrast_factor;
  logic [7:0] saturation_factor;
  logic [7:0] luma_brightness_offset;
  logic [7:0] chroma_hue_angle;
  logic color_adjust_enable;
  logic clamp_a_source_select;
  logic clamp_bc_source_select;
  logic clamp_loop_freeze;
  logic [3:0] clamp_a_high_stage;
  logic [7:0] clamp_b_low_stage;
  logic [3:0] clamp_c_high_stage;
  vca_px_t clamp_a_manual_value;
  vca_px_t clamp_b_manual_value;
  vca_px_t clamp_c_manual_value;
  logic [39:0] fifo_out;
  logic fifo_valid;
  logic take;
  vca_px_t raw_a;
  vca_px_t raw_b;
  vca_px_t raw_c;
  logic raw_hs;
  logic raw_de;
  logic prev_hs;
  logic prev_de;
  logic in_bp;
  logic bp_sample;
  logic line_start;
  vca_px_t loop_a;
  vca_px_t loop_b;
  vca_px_t loop_c;
  logic proc_active;
  logic converter_on;
  logic adjust_on;
  vca_px_t next_a;
  vca_px_t next_b;
  vca_px_t next_c;

  // Host register writes; split clamp values are staged and applied as a whole
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      contrast_factor <= `VCA_RST_CONTRAST;
      saturation_factor <= `VCA_RST_SATURATION;
      luma_brightness_offset <= `VCA_RST_BRIGHTNESS;
      chroma_hue_angle <= `VCA_RST_HUE;
      color_adjust_enable <= 1'(`VCA_RST_ADJ_CTRL >> `VCA_BIT_ADJ_EN);
      clamp_a_source_select <= 1'(`VCA_RST_CLAMP_CTRL >> `VCA_BIT_CLAMP_A_SEL);
      clamp_bc_source_select <= 1'(`VCA_RST_CLAMP_CTRL >> `VCA_BIT_CLAMP_BC_SEL);
      clamp_loop_freeze <= 1'(`VCA_RST_CLAMP_CTRL >> `VCA_BIT_CLAMP_FREEZE);
      clamp_a_high_stage <= 4'h0;
      clamp_b_low_stage <= 8'h00;
      clamp_c_high_stage <= 4'h0;
      clamp_a_manual_value <= `VCA_RST_CLAMP_VALUE;
      clamp_b_manual_value <= `VCA_RST_CLAMP_VALUE;
      clamp_c_manual_value <= `VCA_RST_CLAMP_VALUE;
    end
    else if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        `VCA_ADDR_CONTRAST: contrast_factor <= i_reg_wdata;
        `VCA_ADDR_SATURATION: saturation_factor <= i_reg_wdata;
        `VCA_ADDR_BRIGHTNESS: luma_brightness_offset <= i_reg_wdata;
        `VCA_ADDR_HUE: chroma_hue_angle <= i_reg_wdata;
        `VCA_ADDR_ADJ_CTRL: color_adjust_enable <= i_reg_wdata[`VCA_BIT_ADJ_EN];
        `VCA_ADDR_CLAMP_CTRL:
        begin
          clamp_a_source_select <= i_reg_wdata[`VCA_BIT_CLAMP_A_SEL];
          clamp_bc_source_select <= i_reg_wdata[`VCA_BIT_CLAMP_BC_SEL];
          clamp_loop_freeze <= i_reg_wdata[`VCA_BIT_CLAMP_FREEZE];
          clamp_a_high_stage <= i_reg_wdata[3:0];
        end
        `VCA_ADDR_CLAMP_A_LO: clamp_a_manual_value <= {clamp_a_high_stage, i_reg_wdata};
        `VCA_ADDR_CLAMP_B_LO: clamp_b_low_stage <= i_reg_wdata;
        `VCA_ADDR_CLAMP_BC:
        begin
          clamp_b_manual_value <= {i_reg_wdata[7:4], clamp_b_low_stage};
          clamp_c_high_stage <= i_reg_wdata[3:0];
        end
        `VCA_ADDR_CLAMP_C_LO: clamp_c_manual_value <= {clamp_c_high_stage, i_reg_wdata};
        default: ;
      endcase
    end
  end

  // Register readback, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata <= 8'h00;
    end
    else if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        `VCA_ADDR_CONTRAST: o_reg_rdata <= contrast_factor;
        `VCA_ADDR_SATURATION: o_reg_rdata <= saturation_factor;
        `VCA_ADDR_BRIGHTNESS: o_reg_rdata <= luma_brightness_offset;
        `VCA_ADDR_HUE: o_reg_rdata <= chroma_hue_angle;
        `VCA_ADDR_ADJ_CTRL: o_reg_rdata <= {color_adjust_enable, 7'h00};
        `VCA_ADDR_CLAMP_CTRL: o_reg_rdata <= {clamp_a_source_select, clamp_bc_source_select,
                                              clamp_loop_freeze, 1'b0, clamp_a_high_stage};
        `VCA_ADDR_CLAMP_A_LO: o_reg_rdata <= clamp_a_manual_value[7:0];
        `VCA_ADDR_CLAMP_B_LO: o_reg_rdata <= clamp_b_low_stage;
        `VCA_ADDR_CLAMP_BC: o_reg_rdata <= {clamp_b_manual_value[11:8], clamp_c_high_stage};
        `VCA_ADDR_CLAMP_C_LO: o_reg_rdata <= clamp_c_manual_value[7:0];
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // Input buffer between the preprocessor and the datapath
  vca_fifo #(
    .WIDTH(40),
    .DEPTH(`VCA_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_in_valid(i_px_valid),
    .o_in_ready(o_px_ready),
    .i_in_data({i_hsync, i_vsync, i_field, i_de, i_px_a, i_px_b, i_px_c}),
    .o_out_valid(fifo_valid),
    .i_out_ready(!o_px_valid || i_out_ready),
    .o_out_data(fifo_out)
  );

  assign take = fifo_valid && (!o_px_valid || i_out_ready);
  assign raw_hs = fifo_out[39];
  assign raw_de = fifo_out[36];
  assign raw_a = fifo_out[35:24];
  assign raw_b = fifo_out[23:12];
  assign raw_c = fifo_out[11:0];

  // Mode gating and converter state
  assign proc_active = (i_primary_operating_mode == `VCA_ACTIVE_MODE)
                       && (i_video_standard_select != 6'h00) && !i_pixel_rate_over_limit;
  assign o_bypass_to_formatter = i_pixel_rate_over_limit;
  assign converter_on = i_manual_converter_enable
                        && (i_converter_coefficient_selector == `VCA_COEFF_SEL_MANUAL)
                        && (i_converter_output_scaler == `VCA_SCALE_DEFAULT);
  assign adjust_on = color_adjust_enable && converter_on;
  assign o_preproc_convert = i_input_is_rgb && i_output_is_rgb && color_adjust_enable;

  // Back-porch window: after the sync pulse ends and before active video
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      prev_hs <= 1'b0;
      prev_de <= 1'b0;
      in_bp <= 1'b0;
    end
    else if (take)
    begin
      prev_hs <= raw_hs;
      prev_de <= raw_de;
      if (prev_hs && !raw_hs)
      begin
        in_bp <= 1'b1;
      end
      else if (raw_de)
      begin
        in_bp <= 1'b0;
      end
    end
  end

  assign bp_sample = take && in_bp && !raw_de && !raw_hs;
  assign line_start = take && raw_de && !prev_de;

  vca_clamp_loop u_loop_a (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_bp_sample(bp_sample),
    .i_line_start(line_start),
    .i_freeze(clamp_loop_freeze),
    .i_sample(raw_a),
    .o_level(loop_a)
  );

  vca_clamp_loop u_loop_b (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_bp_sample(bp_sample),
    .i_line_start(line_start),
    .i_freeze(clamp_loop_freeze),
    .i_sample(raw_b),
    .o_level(loop_b)
  );

  vca_clamp_loop u_loop_c (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_bp_sample(bp_sample),
    .i_line_start(line_start),
    .i_freeze(clamp_loop_freeze),
    .i_sample(raw_c),
    .o_level(loop_c)
  );

  // Clamp, colour controls and output offset for the pixel at the buffer head
  always_comb
  begin
    vca_px_t cl_a;
    vca_px_t cl_b;
    vca_px_t cl_c;
    vca_px_t y;
    vca_px_t cb;
    vca_px_t cr;
    vca_wide_t t_y;
    vca_wide_t t_cb;
    vca_wide_t t_cr;
    vca_wide_t s_sin;
    vca_wide_t s_cos;
    vca_wide_t h_cb;
    vca_wide_t h_cr;
    cl_a = (vca_clamp_src_t'(clamp_a_source_select) == VCA_CLAMP_LOOP)
           ? loop_a : clamp_a_manual_value;
    cl_b = (vca_clamp_src_t'(clamp_bc_source_select) == VCA_CLAMP_LOOP)
           ? loop_b : clamp_b_manual_value;
    cl_c = (vca_clamp_src_t'(clamp_bc_source_select) == VCA_CLAMP_LOOP)
           ? loop_c : clamp_c_manual_value;
    y = clip12(vca_wide_t'({20'd0, raw_a}) - vca_wide_t'({20'd0, cl_a}));
    cb = clip12(vca_wide_t'({20'd0, raw_b}) - vca_wide_t'({20'd0, cl_b}));
    cr = clip12(vca_wide_t'({20'd0, raw_c}) - vca_wide_t'({20'd0, cl_c}));
    // Contrast scales luma, brightness code times four is added
    t_y = (vca_wide_t'({20'd0, y}) * vca_wide_t'({24'd0, contrast_factor})) >>> `VCA_UNITY_SHIFT;
    t_y = t_y + (vca_wide_t'(signed'(luma_brightness_offset)) <<< 2);
    // Saturation on centred chroma
    t_cb = ((vca_wide_t'({20'd0, cb}) - `VCA_CHROMA_MID) * vca_wide_t'({24'd0, saturation_factor}))
           >>> `VCA_UNITY_SHIFT;
    t_cr = ((vca_wide_t'({20'd0, cr}) - `VCA_CHROMA_MID) * vca_wide_t'({24'd0, saturation_factor}))
           >>> `VCA_UNITY_SHIFT;
    // Hue rotation, angle linear in the code
    s_sin = hue_sin(chroma_hue_angle);
    s_cos = hue_sin(chroma_hue_angle + 8'h40);
    h_cb = ((t_cb * s_cos) + (t_cr * s_sin)) >>> `VCA_TRIG_SHIFT;
    h_cr = ((t_cr * s_cos) - (t_cb * s_sin)) >>> `VCA_TRIG_SHIFT;
    if (adjust_on)
    begin
      y = clip12(t_y);
      cb = clip12(h_cb + `VCA_CHROMA_MID);
      cr = clip12(h_cr + `VCA_CHROMA_MID);
    end
    // Independent offsets follow, so black may sit above zero
    next_a = clip12(vca_wide_t'({20'd0, y}) + vca_wide_t'({20'd0, i_offset_a}));
    next_b = clip12(vca_wide_t'({20'd0, cb}) + vca_wide_t'({20'd0, i_offset_b}));
    next_c = clip12(vca_wide_t'({20'd0, cr}) + vca_wide_t'({20'd0, i_offset_c}));
    if (!proc_active)
    begin
      next_a = raw_a;
      next_b = raw_b;
      next_c = raw_c;
    end
  end

  // Output valid flag with downstream back-pressure
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_px_valid <= 1'b0;
    end
    else if (take)
    begin
      o_px_valid <= 1'b1;
    end
    else if (i_out_ready)
    begin
      o_px_valid <= 1'b0;
    end
  end

  // Output pixel and timing references, aligned with each other
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_px_a <= 12'h000;
      o_px_b <= 12'h000;
      o_px_c <= 12'h000;
      o_hsync <= 1'b0;
      o_vsync <= 1'b0;
      o_field <= 1'b0;
      o_de <= 1'b0;
    end
    else if (take)
    begin
      o_px_a <= next_a;
      o_px_b <= next_b;
      o_px_c <= next_c;
      o_hsync <= fifo_out[39];
      o_vsync <= fifo_out[38];
      o_field <= fifo_out[37];
      o_de <= fifo_out[36];
    end
  end
endmodule : vca_top

`default_nettype wire

// ### sim/vca_monitor.sv
`default_nettype none
// Watches the register port, the stream handshake and the status flags
module vca_monitor
  import vca_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_input_is_rgb,
  input wire logic i_output_is_rgb,
  input wire logic i_pixel_rate_over_limit,
  input wire logic i_px_valid,
  input wire logic o_px_ready,
  input wire logic o_px_valid,
  input wire logic i_out_ready,
  input wire vca_px_t o_px_a,
  input wire logic o_de,
  input wire logic o_preproc_convert,
  input wire logic o_bypass_to_formatter
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  // Hue write, then its readback two cycles on
  sequence hue_wr_rd;
    i_reg_wr && i_reg_addr == 8'h3d ##2 i_reg_rd && i_reg_addr == 8'h3d;
  endsequence
  // Output word offered but not taken
  sequence stall;
    o_px_valid && !i_out_ready;
  endsequence
  AST_HUE_READBACK:
    assert property (hue_wr_rd |=> o_reg_rdata == $past(i_reg_wdata, 3))
    else $error("hue readback differs");
  AST_UNMAPPED_READ:
    assert property (i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD:
    assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
  AST_BYPASS:
    assert property (o_bypass_to_formatter == i_pixel_rate_over_limit)
    else $error("bypass flag wrong");
  AST_PREPROC:
    assert property (o_preproc_convert |-> i_input_is_rgb && i_output_is_rgb)
    else $error("preprocessor convert without rgb");
  AST_HOLD:
    assert property (stall |=> o_px_valid && $stable(o_px_a) && $stable(o_de))
    else $error("output changed while stalled");
  AST_LATENCY:
    assert property (i_px_valid && o_px_ready && !o_px_valid |-> ##[1:2] o_px_valid)
    else $error("pixel late");
  AST_FULL:
    assert property (!o_px_ready |-> o_px_valid)
    else $error("refusing while output empty");
  AST_POP:
    assert property (o_px_valid && i_out_ready && !o_px_ready |=> o_px_ready)
    else $error("no room after pop");
endmodule : vca_monitor

bind vca_top vca_monitor i_mon (
  .i_ref_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
  .i_input_is_rgb, .i_output_is_rgb, .i_pixel_rate_over_limit, .i_px_valid, .o_px_ready,
  .o_px_valid, .i_out_ready, .o_px_a, .o_de, .o_preproc_convert, .o_bypass_to_formatter
);
`default_nettype wire

// ### sim/vca_src.sv
`default_nettype none
// Upstream preprocessor: offers one word and holds it until taken
module vca_src (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_push,
  input wire logic [39:0] i_word,
  input wire logic i_ready,
  output logic o_valid,
  output logic [39:0] o_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released bus shows the inverse so stale data never passes
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_valid <= 1'b0;
      o_word <= '0;
    end
    else if (i_push)
    begin
      o_valid <= 1'b1;
      o_word <= i_word;
    end
    else if (o_valid && i_ready)
    begin
      o_valid <= 1'b0;
      o_word <= ~o_word;
    end
  end
endmodule : vca_src
`default_nettype wire

// ### sim/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [3:0] i_converter_coefficient_selector = 4'h0;
  logic [3:0] i_primary_operating_mode = 4'h5;
  logic i_input_is_rgb = 1'b0;
  logic i_output_is_rgb = 1'b0;
  logic i_pixel_rate_over_limit = 1'b0;
  logic [11:0] i_offset_a = 12'h000;
  logic i_out_ready = 1'b1;
  logic push = 1'b0;
  logic [39:0] word = 40'h0;
  logic [39:0] s_word;
  logic s_valid;
  logic [7:0] o_reg_rdata;
  logic [11:0] o_px_a, o_px_b, o_px_c;
  logic o_px_ready, o_px_valid, o_hsync, o_vsync, o_field, o_de;
  logic o_preproc_convert, o_bypass_to_formatter;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int acc;
  logic [7:0] ra [8] = '{8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h6c, 8'h6d, 8'h00};
  logic [7:0] rv [8] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] hue [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
  logic [23:0] hbc [4] = '{24'h864800, 24'h80079c, 24'h79c800, 24'h800864};

  vca_top i_dut (
    .i_ref_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_manual_converter_enable(1'b1), .i_converter_coefficient_selector,
    .i_converter_output_scaler(2'h1), .i_input_is_rgb, .i_output_is_rgb,
    .i_primary_operating_mode, .i_video_standard_select(6'h01), .i_pixel_rate_over_limit,
    .i_offset_a, .i_offset_b(12'h000), .i_offset_c(12'h000),
    .i_px_valid(s_valid), .o_px_ready, .i_px_a(s_word[39:28]), .i_px_b(s_word[27:16]),
    .i_px_c(s_word[15:4]), .i_hsync(s_word[3]), .i_vsync(s_word[2]), .i_field(s_word[1]),
    .i_de(s_word[0]), .o_px_valid, .i_out_ready, .o_px_a, .o_px_b, .o_px_c,
    .o_hsync, .o_vsync, .o_field, .o_de, .o_preproc_convert, .o_bypass_to_formatter
  );
  vca_src i_src (
    .i_ref_clk, .i_resetn, .i_push(push), .i_word(word), .i_ready(o_px_ready),
    .o_valid(s_valid), .o_word(s_word)
  );

  // Clock and hang guard
  always #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One register write, then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rdata, exp);
  endtask : rd

  // One pixel through the partner, compared with timing bits at the output
  task automatic send(input logic [11:0] a, b, c, ea, eb, ec);
    int n;
    @(posedge i_ref_clk);
    push <= 1'b1;
    word <= {a, b, c, 4'b0101};
    @(posedge i_ref_clk);
    push <= 1'b0;
    #1;
    for (n = 0; n < 20 && o_px_valid !== 1'b1; n++)
    begin
      @(posedge i_ref_clk);
      #1;
    end
    chk({o_px_a, o_px_b, o_px_c, o_hsync, o_vsync, o_field, o_de}, {ea, eb, ec, 4'b0101});
  endtask : send

  // Main sequence
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(ra[i], rv[i]);
    send(12'h123, 12'h456, 12'h789, 12'h123, 12'h456, 12'h789);
    wr(8'h6c, 8'h05);
    wr(8'h6d, 8'h34);
    rd(8'h6c, 8'h05);
    wr(8'h6e, 8'h10);
    wr(8'h6f, 8'h21);
    wr(8'h70, 8'h05);
    rd(8'h6f, 8'h21);
    send(12'h600, 12'h800, 12'h800, 12'h0cc, 12'h5f0, 12'h6fb);
    send(12'h100, 12'h100, 12'h100, 12'h000, 12'h000, 12'h000);
    wr(8'h6c, 8'hc0);
    send(12'h100, 12'h100, 12'h100, 12'h100, 12'h100, 12'h100);
    for (int i = 0; i < 5; i++)
      wr(8'h6c + i[7:0], 8'h00);
    wr(8'h3c, 8'h7f);
    send(12'h100, 12'h800, 12'h800, 12'h100, 12'h800, 12'h800);
    wr(8'h3e, 8'h80);
    send(12'h100, 12'h800, 12'h800, 12'h2fc, 12'h800, 12'h800);
    wr(8'h3c, 8'h80);
    send(12'h300, 12'h800, 12'h800, 12'h100, 12'h800, 12'h800);
    wr(8'h3c, 8'h00);
    wr(8'h3a, 8'h40);
    send(12'h200, 12'h800, 12'h800, 12'h100, 12'h800, 12'h800);
    wr(8'h3a, 8'h80);
    wr(8'h3b, 8'h40);
    send(12'h100, 12'h8c8, 12'h800, 12'h100, 12'h864, 12'h800);
    wr(8'h3b, 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h3d, hue[i]);
      rd(8'h3d, hue[i]);
      send(12'h100, 12'h864, 12'h800, 12'h100, hbc[i][23:12], hbc[i][11:0]);
    end
    @(posedge i_ref_clk);
    i_converter_coefficient_selector <= 4'h1;
    send(12'h100, 12'h864, 12'h800, 12'h100, 12'h864, 12'h800);
    @(posedge i_ref_clk);
    i_converter_coefficient_selector <= 4'h0;
    i_primary_operating_mode <= 4'h4;
    send(12'h100, 12'h864, 12'h800, 12'h100, 12'h864, 12'h800);
    @(posedge i_ref_clk);
    i_primary_operating_mode <= 4'h5;
    i_offset_a <= 12'h010;
    wr(8'h3d, 8'h00);
    send(12'h100, 12'h800, 12'h800, 12'h110, 12'h800, 12'h800);
    @(posedge i_ref_clk);
    i_input_is_rgb <= 1'b1;
    i_output_is_rgb <= 1'b1;
    i_pixel_rate_over_limit <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    chk({o_preproc_convert, o_bypass_to_formatter}, 2'b11);
    @(posedge i_ref_clk);
    i_output_is_rgb <= 1'b0;
    i_pixel_rate_over_limit <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk({o_preproc_convert, o_bypass_to_formatter}, 2'b00);
    // Fill the buffer with the sink stalled, then drain it
    @(posedge i_ref_clk);
    i_out_ready <= 1'b0;
    acc = 0;
    for (int k = 0; k < 12; k++)
    begin
      @(posedge i_ref_clk);
      push <= 1'b1;
      word <= {36'h100800800, 4'b0101};
      @(posedge i_ref_clk);
      push <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      if (s_valid === 1'b1)
        break;
      acc++;
    end
    chk(acc, 9);
    @(posedge i_ref_clk);
    i_out_ready <= 1'b1;
    acc = 0;
    repeat (30)
    begin
      #1;
      if (o_px_valid === 1'b1)
        acc++;
      @(posedge i_ref_clk);
    end
    chk(acc, 10);
    test_done();
  end
endmodule : tb
`default_nettype wire
